// file: spimcc_pkg.sv
// shared constants and carrier types of the serial master clock and control block
package spimcc_pkg;

  // register byte offsets (word aligned)
  localparam logic [4:0] OFF_PRESCALER = 5'h00;
  localparam logic [4:0] OFF_CONTROL   = 5'h04;
  localparam logic [4:0] OFF_STATUS    = 5'h08;
  localparam logic [4:0] OFF_DATA      = 5'h0C;
  localparam logic [4:0] OFF_IRQ_MASK  = 5'h10;

  // control field positions
  localparam int CTL_IRQ_ENABLE = 7;
  localparam int CTL_SYSTEM_ON  = 6;
  localparam int CTL_RESERVED   = 5;
  localparam int CTL_MASTER     = 4;
  localparam int CTL_POLARITY   = 3;
  localparam int CTL_PHASE      = 2;

  // status field positions
  localparam int STS_DONE = 7;
  localparam int STS_WCOL = 6;
  localparam int STS_BUSY = 0;

  // values after reset, and the mask of the sticky status bits
  localparam logic [7:0] RST_PRESCALER = 8'h00;
  localparam logic [7:0] RST_CONTROL   = 8'h10;
  localparam logic [7:0] RST_IRQ_MASK  = 8'hC0;
  localparam logic [7:0] STICKY_MASK   = 8'hC0;

  // prescaled clocks per half serial clock for each rate code
  localparam logic [4:0] RATE_DIV_0 = 5'h02;
  localparam logic [4:0] RATE_DIV_1 = 5'h04;
  localparam logic [4:0] RATE_DIV_2 = 5'h08;
  localparam logic [4:0] RATE_DIV_3 = 5'h10;

  // serial clock edges per byte: eight cycles, two edges each
  localparam logic [4:0] EDGES_PER_BYTE = 5'h10;

  typedef struct packed {
    logic       read;
    logic       write;
    logic [2:0] address;
    logic [7:0] writedata;
  } spimcc_req_s;

  typedef struct packed {
    logic       sck;
    logic       mosi;
  } spimcc_pins_s;

endpackage : spimcc_pkg

// file: spimcc_clkdiv.sv
// prescaler and rate divisor producing half serial clock ticks
`timescale 1ns/1ps
module spimcc_clkdiv (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       reset,
  // configuration
  input  wire logic       run,
  input  wire logic [7:0] prescaler_count,
  input  wire logic [1:0] rate_select_field,
  // timing
  output logic            half_tick
);

  typedef struct packed {
    logic [7:0] pre_cnt;
    logic [4:0] rate_cnt;
    logic       tick;
  } spimcc_div_s;

  spimcc_div_s st;
  spimcc_div_s next_st;
  logic [4:0]  rate_div;

  always_comb begin
    unique case (rate_select_field)
      2'b00: rate_div = spimcc_pkg::RATE_DIV_0;
      2'b01: rate_div = spimcc_pkg::RATE_DIV_1;
      2'b10: rate_div = spimcc_pkg::RATE_DIV_2;
      2'b11: rate_div = spimcc_pkg::RATE_DIV_3;
    endcase
  end

  always_comb begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (!run) begin
      next_st.pre_cnt  = '0;
      next_st.rate_cnt = '0;
    end else if (st.pre_cnt == prescaler_count) begin
      next_st.pre_cnt = '0;
      if (st.rate_cnt == rate_div - 5'h01) begin
        next_st.rate_cnt = '0;
        next_st.tick     = 1'b1;
      end else begin
        next_st.rate_cnt = st.rate_cnt + 5'h01;
      end
    end else begin
      next_st.pre_cnt = st.pre_cnt + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign half_tick = st.tick;

endmodule : spimcc_clkdiv

// file: spimcc_top.sv
// serial master: registers, interrupt and byte shift engine
`timescale 1ns/1ps
// Functional notes
// - prescaler count field in clock register bits 7:0
// - control register resets to 0x10
// - bit 7 enables interrupt on done flag
// - bit 6 switches serial system on/off
// - bit 4 master select, fixed at one
// - bit 3 sets serial clock idle level
// - bit 2 picks first or second latch edge
// - bits 1:0 select one of four rates
// - rate code 00 divides the prescaled clock by four, two per half period
// - counter versus prescaler times half periods
// - eight clocks after data write set done
module spimcc_top (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // avalon-mm slave
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // interrupt
  output logic             irq,
  // serial pins
  output logic             sck,
  output logic             mosi,
  input  wire logic        miso
);

  typedef struct packed {
    logic [7:0]  prescaler;
    logic [7:0]  control;
    logic [7:0]  status;
    logic [7:0]  irq_mask;
    logic        armed;
    logic        busy;
    logic [4:0]  edges;
    logic [7:0]  shifter;
    logic [7:0]  rx_data;
    logic        sck;
    logic        mosi;
    logic        irq;
    logic        waitreq;
    logic [31:0] rdata;
    logic [1:0]  miso_sync;
  } spimcc_state_s;

  spimcc_state_s        st;
  spimcc_state_s        next_st;
  spimcc_pkg::spimcc_req_s req;
  logic                 half_tick;
  logic                 take;
  logic                 leading;
  logic                 sample_edge;
  logic [4:0]           word_off;
  logic [7:0]           wbyte;
  logic [7:0]           rbyte;

  // one driver for the whole request word
  assign req           = {avs_read, avs_write, avs_address, avs_writedata[7:0]};
  assign take          = (req.read | req.write) & st.waitreq;
  assign word_off      = {req.address, 2'b00};
  assign wbyte         = req.writedata;
  // leading edge when the edge count is even
  assign leading       = ~st.edges[0];
  assign sample_edge   = leading ^ st.control[spimcc_pkg::CTL_PHASE];

  spimcc_clkdiv u_clkdiv (
    .mclk              (mclk),
    .reset             (reset),
    .run               (st.busy),
    .prescaler_count   (st.prescaler),
    .rate_select_field (st.control[1:0]),
    .half_tick         (half_tick)
  );

  always_comb begin
    rbyte = 8'h00;
    unique case (word_off)
      spimcc_pkg::OFF_PRESCALER: rbyte = st.prescaler;
      spimcc_pkg::OFF_CONTROL:   rbyte = st.control;
      spimcc_pkg::OFF_STATUS:    rbyte = st.status | {7'h00, st.busy};
      spimcc_pkg::OFF_DATA:      rbyte = st.rx_data;
      spimcc_pkg::OFF_IRQ_MASK:  rbyte = st.irq_mask;
      default:                   rbyte = 8'h00;
    endcase
  end

  always_comb begin
    next_st           = st;
    // miso comes from another chip: two flops before use
    next_st.miso_sync = {st.miso_sync[0], miso};

    // one wait cycle, then a single-cycle answer
    next_st.waitreq = ~take;
    if (take && req.read) begin
      next_st.rdata = {24'h00_0000, rbyte};
    end

    // shift engine
    if (!st.control[spimcc_pkg::CTL_SYSTEM_ON]) begin
      next_st.busy  = 1'b0;
      next_st.edges = '0;
      next_st.sck   = st.control[spimcc_pkg::CTL_POLARITY];
    end else if (!st.busy) begin
      next_st.sck = st.control[spimcc_pkg::CTL_POLARITY];
    end else if (half_tick) begin
      next_st.sck = ~st.sck;
      if (sample_edge) begin
        next_st.shifter = {st.shifter[6:0], st.miso_sync[1]};
      end else begin
        next_st.mosi = st.shifter[7];
      end
      if (st.edges == spimcc_pkg::EDGES_PER_BYTE - 5'h01) begin
        next_st.busy    = 1'b0;
        next_st.edges   = '0;
        // phase 0 ends on a drive edge, so all eight bits are already in
        next_st.rx_data = sample_edge ? {st.shifter[6:0], st.miso_sync[1]} : st.shifter;
        next_st.mosi    = st.mosi;
      end else begin
        next_st.edges = st.edges + 5'h01;
      end
    end

    // register writes and access side effects
    if (take && req.write) begin
      unique case (word_off)
        spimcc_pkg::OFF_PRESCALER: next_st.prescaler = wbyte;
        spimcc_pkg::OFF_CONTROL: begin
          next_st.control = wbyte;
          // reserved bit stays zero, slave mode is not offered
          next_st.control[spimcc_pkg::CTL_RESERVED] = 1'b0;
          next_st.control[spimcc_pkg::CTL_MASTER]   = 1'b1;
        end
        spimcc_pkg::OFF_STATUS:   next_st.status   = st.status & ~(wbyte & spimcc_pkg::STICKY_MASK);
        spimcc_pkg::OFF_IRQ_MASK: next_st.irq_mask = wbyte & spimcc_pkg::STICKY_MASK;
        spimcc_pkg::OFF_DATA: begin
          if (st.busy) begin
            next_st.status[spimcc_pkg::STS_WCOL] = 1'b1;
          end else if (st.control[spimcc_pkg::CTL_SYSTEM_ON]
                       && (!st.status[spimcc_pkg::STS_DONE] || st.armed)) begin
            next_st.busy    = 1'b1;
            next_st.edges   = '0;
            next_st.shifter = wbyte;
            // leading-edge latch needs the first bit out before any edge
            if (!st.control[spimcc_pkg::CTL_PHASE]) begin
              next_st.mosi = wbyte[7];
            end
          end
        end
        default: ;
      endcase
    end

    // status read arms the clear, next data access completes it
    if (take && word_off == spimcc_pkg::OFF_STATUS && req.read) begin
      next_st.armed = st.status[spimcc_pkg::STS_DONE] | st.status[spimcc_pkg::STS_WCOL];
    end else if (take && word_off == spimcc_pkg::OFF_DATA) begin
      if (st.armed) begin
        next_st.status[spimcc_pkg::STS_DONE] = 1'b0;
        next_st.status[spimcc_pkg::STS_WCOL] = 1'b0;
      end
      next_st.armed = 1'b0;
    end

    // hardware set wins over any clear in the same cycle
    if (st.busy && half_tick && st.control[spimcc_pkg::CTL_SYSTEM_ON]
        && st.edges == spimcc_pkg::EDGES_PER_BYTE - 5'h01) begin
      next_st.status[spimcc_pkg::STS_DONE] = 1'b1;
    end
    if (take && req.write && word_off == spimcc_pkg::OFF_DATA && st.busy) begin
      next_st.status[spimcc_pkg::STS_WCOL] = 1'b1;
    end

    next_st.irq = next_st.control[spimcc_pkg::CTL_IRQ_ENABLE]
                  & |(next_st.status & next_st.irq_mask);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st           <= '0;
      st.prescaler <= spimcc_pkg::RST_PRESCALER;
      st.control   <= spimcc_pkg::RST_CONTROL;
      st.irq_mask  <= spimcc_pkg::RST_IRQ_MASK;
      st.waitreq   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata    = st.rdata;
  assign avs_waitrequest = st.waitreq;
  assign irq             = st.irq;
  assign sck             = st.sck;
  assign mosi            = st.mosi;

endmodule : spimcc_top

// file: spimcc_properties.sv
// assertions on the serial master bus, interrupt and clock pin
`timescale 1ns/1ps
module spimcc_properties (
  // clock and reset
  input wire logic        mclk,
  input wire logic        reset,
  // register bus and pins
  input wire logic [2:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        irq,
  input wire logic        sck
);
  logic [7:0] ctl;
  logic       req;
  logic       ack;
  logic       cwr;
  assign req = avs_read | avs_write;
  assign ack = req & ~avs_waitrequest;
  assign cwr = avs_write & (avs_address == 3'h1);
  // shadow of control, taken when the write is answered
  always_ff @(posedge mclk) begin
    if (reset)
      ctl <= 8'h10;
    else if (ack && cwr)
      ctl <= avs_writedata[7:0];
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  a_bus_answer: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer longer than one cycle");
  a_no_spurious: assert property (!req |=> avs_waitrequest)
    else $error("answer without request");
  a_read_upper: assert property (ack && avs_read |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_ctl_fixed: assert property (
    ack && avs_read && avs_address == 3'h1 |-> avs_readdata[5:4] == 2'b01)
    else $error("fixed control bits wrong");
  a_irq_gate: assert property (!ctl[7] |-> !irq)
    else $error("irq while disabled");
  a_sck_parked: assert property (!ctl[6] && $stable(ctl) |-> sck == ctl[3])
    else $error("clock not parked");
  a_half_min: assert property (ctl[6] && !cwr && $changed(sck) |=> $stable(sck))
    else $error("half period too short");
endmodule : spimcc_properties

bind spimcc_top spimcc_properties chk_u (.mclk(mclk), .reset(reset), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .sck(sck));

// file: spimcc_slave_model.sv
// serial peripheral on the far side: shifts a byte out and in
`timescale 1ns/1ps
module spimcc_slave_model (
  // clock
  input wire logic       mclk,
  // serial pins
  input wire logic       sck,
  input wire logic       mosi,
  output logic           miso,
  // setup from the bench
  input wire logic       clock_polarity_bit,
  input wire logic       clock_phase_bit,
  input wire logic       load,
  input wire logic [7:0] tx,
  output logic [7:0]     rx
);
  logic [7:0] sh;
  logic       sck_q;
  logic       first;
  logic       lead;
  logic       trail;
  assign lead  = (sck_q == clock_polarity_bit) && (sck != clock_polarity_bit);
  assign trail = (sck_q != clock_polarity_bit) && (sck == clock_polarity_bit);
  assign miso  = sh[7];
  // edges seen one system clock late, well inside a half period
  always @(posedge mclk) begin
    sck_q <= sck;
    if (load) begin
      sh    <= tx;
      first <= clock_phase_bit;
    end else if (clock_phase_bit ? trail : lead) begin
      rx <= {rx[6:0], mosi};
    end else if (clock_phase_bit ? lead : trail) begin
      first <= 1'b0;
      // past the last bit the line keeps changing rather than holding
      sh    <= first ? sh : {sh[6:0], ~sh[0]};
    end
  end
endmodule : spimcc_slave_model

// file: test_spi_master_clock_and_control.sv
// self-checking bench of the serial master registers and byte transfer
`timescale 1ns/1ps
module test_spi_master_clock_and_control;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic [2:0]  avs_address = 3'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        sck;
  logic        mosi;
  logic        miso;
  logic        clock_polarity_bit = 1'b0;
  logic        clock_phase_bit = 1'b0;
  logic        load = 1'b0;
  logic [7:0]  tx = 8'h00;
  logic [7:0]  rx;
  logic [31:0] q;
  int          bad_count = 0;
  int          n_tests = 0;
  int          n;
  int          h;
  always #5 mclk = ~mclk;
  spimcc_top dut_u (.mclk(mclk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .sck(sck), .mosi(mosi), .miso(miso));
  spimcc_slave_model peer_u (.mclk(mclk), .sck(sck), .mosi(mosi), .miso(miso),
    .clock_polarity_bit(clock_polarity_bit), .clock_phase_bit(clock_phase_bit), .load(load), .tx(tx), .rx(rx));
  task final_report;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task check(input string s, input logic [31:0] seen, input logic [31:0] e);
    n_tests++;
    if (seen !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", s, e, seen);
    end
  endtask : check
  task acc(input logic wr, input logic [2:0] a, input logic [7:0] d);
    int k;
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write     <= wr;
    avs_read      <= !wr;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50)
      check("bus answer", 1'b0, 1'b1);
    if (k >= 50)
      final_report();
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : acc
  task rd(input logic [2:0] a, input logic [31:0] e, input string s);
    acc(1'b0, a, 8'h00);
    check(s, q, e);
  endtask : rd
  initial begin
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    rd(3'h0, 32'h0000_0000, "prescaler reset");
    rd(3'h1, 32'h0000_0010, "control reset");
    rd(3'h4, 32'h0000_00C0, "mask reset");
    acc(1'b1, 3'h5, 8'hFF);
    rd(3'h5, 32'h0000_0000, "unmapped");
    acc(1'b1, 3'h1, 8'h3F);
    rd(3'h1, 32'h0000_001F, "control fixed bits");
    check("off idle high", sck, 1'b1);
    acc(1'b1, 3'h1, 8'h00);
    rd(3'h1, 32'h0000_0010, "master bit");
    acc(1'b1, 3'h0, 8'hA5);
    rd(3'h0, 32'h0000_00A5, "prescaler rw");
    acc(1'b1, 3'h0, 8'h03);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      clock_polarity_bit <= i[1];
      clock_phase_bit <= i[0];
      tx   <= 8'h5A ^ i[7:0];
      load <= 1'b1;
      acc(1'b1, 3'h1, {4'hD, i[1:0], i[1:0]});
      // hold load until a new idle level has reached the peer
      @(posedge mclk);
      load <= 1'b0;
      acc(1'b1, 3'h3, 8'hC3 ^ i[7:0]);
      h = 4 * (2 << i);
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
        @(posedge mclk);
        n++;
      end
      check("byte time", n >= 16 * h - 2 && n <= 16 * h + 4, 1'b1);
      if (n >= 3000)
        final_report();
      check("idle level", sck, i[1]);
      acc(1'b1, 3'h1, {4'h5, i[1:0], i[1:0]});
      @(posedge mclk);
      check("irq masked", irq, 1'b0);
      rd(3'h2, 32'h0000_0080, "done flag");
      rd(3'h3, {24'h00_0000, 8'h5A ^ i[7:0]}, "rx byte");
      check("tx byte", rx, 8'hC3 ^ i[7:0]);
      acc(1'b1, 3'h1, {4'hD, i[1:0], i[1:0]});
      @(posedge mclk);
      check("irq cleared", irq, 1'b0);
      $display("test mode %0d done", i);
    end
    acc(1'b1, 3'h4, 8'h7F);
    rd(3'h4, 32'h0000_0040, "mask rw");
    acc(1'b1, 3'h1, 8'hC8);
    acc(1'b1, 3'h3, 8'hAA);
    acc(1'b1, 3'h3, 8'h55);
    rd(3'h2, 32'h0000_0041, "collision flag");
    check("collision irq", irq, 1'b1);
    acc(1'b1, 3'h2, 8'h40);
    rd(3'h2, 32'h0000_0001, "collision cleared");
    check("irq after clear", irq, 1'b0);
    $display("test collision done");
    acc(1'b1, 3'h1, 8'h08);
    repeat (2) @(posedge mclk);
    check("parked high", sck, 1'b1);
    final_report();
  end
endmodule : test_spi_master_clock_and_control
